/* logic/bst_pkg.sv */
package bst_pkg;
  localparam int WORD_W = 60;
  localparam int ADDR_W = 18;
  localparam int DM_AW = 14;
  localparam int BANKS = 4;
  localparam int BANK_AW = 2;
  localparam int BANK_WORDS = 4096;
  localparam int OP_W = 6;
  localparam int STAT_W = 18;
  localparam int FIFO_DEPTH = 8;
  localparam logic [OP_W-1:0] OP_XFER = 6'h16;
  localparam logic [OP_W-1:0] OP_STAT = 6'h17;
  localparam int DIR_BIT = 0;
  localparam logic DIR_TO_DM = 1'h0;
  localparam logic DIR_TO_BULK = 1'h1;
  localparam int STAT_LIVE = 17;
  localparam int STAT_ABORT = 16;
  localparam int STAT_PARITY = 15;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 18'h1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h0;
  localparam int CLK_NS = 25;
  localparam int MAJOR_NS = 1000;
  localparam int MAJOR_CYC = (MAJOR_NS + CLK_NS - 1) / CLK_NS;
  localparam int MCYC_W = 6;
  localparam logic [MCYC_W-1:0] MAJOR_CYC_V = MCYC_W'(MAJOR_CYC);
  localparam logic [MCYC_W-1:0] MCYC_ZERO = 6'h0;
  localparam logic [MCYC_W-1:0] MCYC_LAST = 6'h1;

  // descriptor word fetched from the distributive memory
  typedef struct packed {
    logic [5:0] spare;
    logic [ADDR_W-1:0] cnt;
    logic [ADDR_W-1:0] dm_addr;
    logic [ADDR_W-1:0] bs_addr;
  } bst_desc_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DESC = 2'h1,
    ST_RUN = 2'h2,
    ST_DONE = 2'h3
  } bst_state_t;
endpackage

/* logic/bst_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module bst_fifo #(
  parameter int W = 60,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [PW-1:0] PTR_ONE = PW'(1);

  logic [W-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  wire logic push = in_valid_i & in_ready_o;
  wire logic pop = out_valid_o & out_ready_i;
  wire logic [CW-1:0] next_count = push & ~pop ? CW'(count + CNT_ONE) :
                                   pop & ~push ? CW'(count - CNT_ONE) : count;

  assign out_data_o = store[rd_ptr];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      store[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'h0;
      out_valid_o <= 1'h0;
    end else begin
      wr_ptr <= push ? PW'(wr_ptr + PTR_ONE) : wr_ptr;
      rd_ptr <= pop ? PW'(rd_ptr + PTR_ONE) : rd_ptr;
      count <= next_count;
      in_ready_o <= next_count != FULL_CNT;
      out_valid_o <= next_count != '0;
    end
  end
endmodule // bst_fifo
`default_nettype wire

/* logic/bst_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bst_top
  import bst_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic instr_valid_i,
  input wire logic [OP_W-1:0] opcode_i,
  input wire logic [OP_W-1:0] d_field_i,
  input wire logic [ADDR_W-1:0] acc_i,
  output logic instr_done_o,
  output logic busy_o,
  output logic [STAT_W-1:0] status_o,
  input wire logic bulk_attached_i,
  input wire logic coupler_live_i,
  input wire logic bs_abort_i,
  input wire logic bs_parity_err_i,
  output logic bs_rd_req_o,
  output logic [ADDR_W-1:0] bs_rd_addr_o,
  output logic [ADDR_W-1:0] bs_rd_count_o,
  input wire logic bs_rdata_valid_i,
  output logic bs_rdata_ready_o,
  input wire logic [WORD_W-1:0] bs_rdata_i,
  output logic bs_wr_valid_o,
  input wire logic bs_wr_ready_i,
  output logic [WORD_W-1:0] bs_wr_data_o,
  output logic [ADDR_W-1:0] bs_wr_addr_o
);
  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [2:0] live_s;
  logic [2:0] att_s;
  logic live;
  logic attached;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      live_s <= 3'h0;
      att_s <= 3'h0;
      live <= 1'h0;
      attached <= 1'h0;
    end else begin
      live_s <= {live_s[1:0], coupler_live_i};
      att_s <= {att_s[1:0], bulk_attached_i};
      live <= (live_s[1] == live_s[2]) ? live_s[2] : live;
      attached <= (att_s[1] == att_s[2]) ? att_s[2] : attached;
    end
  end

  // ************************************************
  // distributive memory, four interleaved banks
  // ************************************************
  function automatic logic [BANK_AW-1:0] bank_of(input logic [ADDR_W-1:0] a);
    return a[BANK_AW-1:0];
  endfunction

  function automatic logic [DM_AW-BANK_AW-1:0] row_of(input logic [ADDR_W-1:0] a);
    return a[DM_AW-1:BANK_AW];
  endfunction

  logic [WORD_W-1:0] bank_mem [BANKS][BANK_WORDS];
  logic [WORD_W-1:0] mem_rd;
  logic [MCYC_W-1:0] mem_cnt;

  bst_state_t state;
  logic dir;
  logic [ADDR_W-1:0] remaining;
  logic [ADDR_W-1:0] to_read;
  logic [ADDR_W-1:0] dm_addr;
  logic [ADDR_W-1:0] bs_addr;
  logic abort_flag;
  logic parity_flag;

  wire logic in_idle = state == ST_IDLE;
  wire logic in_run = state == ST_RUN;
  wire logic mem_idle = mem_cnt == MCYC_ZERO;
  wire logic mem_done = mem_cnt == MCYC_LAST;
  wire logic take = in_idle & instr_valid_i;
  wire logic stat_op = take & (opcode_i == OP_STAT);
  wire logic xfer_op = take & (opcode_i == OP_XFER);
  wire logic xfer_go = xfer_op & attached;
  wire logic xfer_pass = xfer_op & ~attached;
  wire bst_desc_t desc = mem_rd;

  // fifo handshakes
  logic rf_ready;
  logic rf_valid;
  logic [WORD_W-1:0] rf_data;
  logic wf_ready;
  wire logic rf_pop = in_run & (dir == DIR_TO_DM) & mem_idle & rf_valid;
  wire logic wf_start = in_run & (dir == DIR_TO_BULK) & mem_idle & wf_ready
                        & (to_read != ADDR_ZERO);
  wire logic wf_push = in_run & (dir == DIR_TO_BULK) & mem_done;
  wire logic wr_beat = bs_wr_valid_o & bs_wr_ready_i;
  wire logic mem_start = xfer_go | rf_pop | wf_start;
  wire logic [ADDR_W-1:0] rd_addr = in_idle ? acc_i : dm_addr;
  wire logic run_end = in_run & (remaining == ADDR_ZERO) & mem_idle;

  // one read-write per major cycle per access
  // plain always: descriptor words may also be placed in the banks from outside this process
  always @(posedge ref_clk_i) begin
    if (rf_pop) begin
      bank_mem[bank_of(dm_addr)][row_of(dm_addr)] <= rf_data;
    end
    if (mem_start) begin
      mem_rd <= bank_mem[bank_of(rd_addr)][row_of(rd_addr)];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      mem_cnt <= MCYC_ZERO;
    end else begin
      mem_cnt <= mem_start ? MAJOR_CYC_V :
                 mem_idle ? MCYC_ZERO : MCYC_W'(mem_cnt - MCYC_LAST);
    end
  end

  // ************************************************
  // transfer sequencer
  // ************************************************
  wire bst_state_t next_state =
    xfer_go ? ST_DESC :
    (state == ST_DESC) & mem_done ? ((desc.cnt == ADDR_ZERO) ? ST_DONE : ST_RUN) :
    run_end ? ST_DONE :
    (state == ST_DONE) ? ST_IDLE : state;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      busy_o <= 1'h0;
      instr_done_o <= 1'h0;
    end else begin
      state <= next_state;
      busy_o <= next_state != ST_IDLE;
      instr_done_o <= stat_op | xfer_pass | (state == ST_DONE);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      dir <= DIR_TO_DM;
      remaining <= ADDR_ZERO;
      to_read <= ADDR_ZERO;
      dm_addr <= ADDR_ZERO;
      bs_addr <= ADDR_ZERO;
      bs_rd_req_o <= 1'h0;
      bs_rd_addr_o <= ADDR_ZERO;
      bs_rd_count_o <= ADDR_ZERO;
    end else begin
      bs_rd_req_o <= 1'h0;
      if (xfer_go) begin
        dir <= d_field_i[DIR_BIT];
      end
      if ((state == ST_DESC) & mem_done) begin
        remaining <= desc.cnt;
        to_read <= desc.cnt;
        dm_addr <= desc.dm_addr;
        bs_addr <= desc.bs_addr;
        bs_rd_req_o <= (dir == DIR_TO_DM) & (desc.cnt != ADDR_ZERO);
        bs_rd_addr_o <= desc.bs_addr;
        bs_rd_count_o <= desc.cnt;
      end
      if (rf_pop | wf_start) begin
        dm_addr <= ADDR_W'(dm_addr + ADDR_STEP);
      end
      if (wf_start) begin
        to_read <= ADDR_W'(to_read - ADDR_STEP);
      end
      if (rf_pop | wr_beat) begin
        bs_addr <= ADDR_W'(bs_addr + ADDR_STEP);
        remaining <= ADDR_W'(remaining - ADDR_STEP);
      end
    end
  end

  // ************************************************
  // coupler status
  // ************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      abort_flag <= 1'h0;
      parity_flag <= 1'h0;
      status_o <= '0;
    end else begin
      abort_flag <= bs_abort_i | (abort_flag & ~xfer_go);
      parity_flag <= bs_parity_err_i | (parity_flag & ~xfer_go);
      status_o <= '0;
      status_o[STAT_LIVE] <= live;
      status_o[STAT_ABORT] <= abort_flag;
      status_o[STAT_PARITY] <= parity_flag;
    end
  end

  assign bs_wr_addr_o = bs_addr;

  // ************************************************
  // word buffers, one per direction
  // ************************************************
  bst_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_rd_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(bs_rdata_valid_i & in_run & (dir == DIR_TO_DM)),
    .in_ready_o(rf_ready),
    .in_data_i(bs_rdata_i),
    .out_valid_o(rf_valid),
    .out_ready_i(rf_pop),
    .out_data_o(rf_data)
  );
  assign bs_rdata_ready_o = rf_ready;

  bst_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_wr_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(wf_push),
    .in_ready_o(wf_ready),
    .in_data_i(mem_rd),
    .out_valid_o(bs_wr_valid_o),
    .out_ready_i(bs_wr_ready_i),
    .out_data_o(bs_wr_data_o)
  );

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence desc_wait_s;
    (state == ST_DESC) ##39 (state == ST_DESC) ##1 (state != ST_DESC);
  endsequence

  status_read_a: assert property (stat_op |=> instr_done_o && !busy_o)
    else $error("status read did not finish in one cycle");
  no_bulk_pass_a: assert property (xfer_pass |=> instr_done_o && !busy_o
      && $stable(dm_addr) && $stable(remaining))
    else $error("transfer without bulk store changed state");
  desc_fetch_a: assert property (xfer_go |=> desc_wait_s)
    else $error("descriptor fetch did not take one major cycle");
  flag_clear_a: assert property (xfer_go && !bs_abort_i && !bs_parity_err_i
      |=> !abort_flag && !parity_flag)
    else $error("status bits 16 and 15 not cleared at transfer start");
  live_follow_a: assert property ((live_s[1] == live_s[2])
      |=> ##1 status_o[STAT_LIVE] == $past(live_s[2], 2))
    else $error("live status bit did not follow its input");
  dir_select_a: assert property ((state == ST_DESC) && mem_done && desc.cnt != ADDR_ZERO
      |=> bs_rd_req_o == (dir == DIR_TO_DM))
    else $error("direction selector chose the wrong operation");
  to_dm_step_a: assert property (rf_pop |=> remaining == ADDR_W'($past(remaining) - ADDR_STEP)
      && dm_addr == ADDR_W'($past(dm_addr) + ADDR_STEP))
    else $error("bulk to memory word did not step");
  to_bulk_step_a: assert property (wr_beat |=> bs_addr == ADDR_W'($past(bs_addr) + ADDR_STEP)
      && remaining == ADDR_W'($past(remaining) - ADDR_STEP))
    else $error("memory to bulk word did not step");
  bank_cycle_a: assert property (mem_start |-> ##40 mem_done)
    else $error("memory access not one major cycle");
  xfer_end_a: assert property (run_end |=> (state == ST_DONE) ##1 instr_done_o)
    else $error("transfer did not end after its count");
endmodule // bst_top
`default_nettype wire

/* dv/bst_bulk_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bst_bulk_model
  import bst_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic rd_req_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  input wire logic [ADDR_W-1:0] rd_count_i,
  output logic rdata_valid_o,
  input wire logic rdata_ready_i,
  output logic [WORD_W-1:0] rdata_o,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WORD_W-1:0] wr_data_i,
  input wire logic [ADDR_W-1:0] wr_addr_i
);
  int pending;
  int n_rd;
  int n_wr;
  int wr_err;
  bit has_wr;
  logic [ADDR_W-1:0] src;
  logic [ADDR_W-1:0] next_wr;
  logic [WORD_W-1:0] last_wr;

  // **********************************************
  // bulk store side: supplies words, sinks writes
  // **********************************************
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      pending = 0;
      n_rd = 0;
      n_wr = 0;
      wr_err = 0;
      has_wr = 0;
      rdata_valid_o <= 1'b0;
      wr_ready_o <= 1'b0;
      rdata_o <= '0;
    end else begin
      if (rd_req_i) begin
        pending = int'(rd_count_i);
        src = rd_addr_i;
      end
      if (rdata_valid_o && rdata_ready_i) begin
        n_rd++;
        pending--;
        src = src + ADDR_STEP;
      end
      // a word on offer is held until taken
      if (!(rdata_valid_o && !rdata_ready_i)) begin
        if (pending > 0 && ($urandom % 4) != 0) begin
          rdata_valid_o <= 1'b1;
          rdata_o <= {6'h2A, src, ~src, src};
        end else begin
          rdata_valid_o <= 1'b0;
          rdata_o <= ~rdata_o;
        end
      end
      if (wr_valid_i && wr_ready_o) begin
        if (has_wr && wr_addr_i !== next_wr) wr_err++;
        next_wr = wr_addr_i + ADDR_STEP;
        has_wr = 1;
        n_wr++;
        last_wr = wr_data_i;
      end
      wr_ready_o <= (($urandom % 3) != 0);
    end
  end
endmodule // bst_bulk_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bst_pkg::*;
;
  logic ref_clk_i, rst_b_i, instr_valid_i, instr_done_o, busy_o;
  logic [OP_W-1:0] opcode_i, d_field_i, op;
  logic [ADDR_W-1:0] acc_i, bs_rd_addr_o, bs_rd_count_o, bs_wr_addr_o;
  logic [STAT_W-1:0] status_o, snap;
  logic bulk_attached_i, coupler_live_i, bs_abort_i, bs_parity_err_i, live;
  logic bs_rd_req_o, bs_rdata_valid_i, bs_rdata_ready_o, bs_wr_valid_o, bs_wr_ready_i;
  logic [WORD_W-1:0] bs_rdata_i, bs_wr_data_o;
  int err_total, n_checks, cyc, acc_cyc, req_cyc, req_cnt, n, rd0, k;
  bit req_seen, seen, w_ok;
  logic [ADDR_W-1:0] dm_a, bs1, bs2, wa, req_addr, exp_addr;
  logic [WORD_W-1:0] exp_q[$];

  bst_top u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i),
    .opcode_i(opcode_i), .d_field_i(d_field_i), .acc_i(acc_i), .instr_done_o(instr_done_o),
    .busy_o(busy_o), .status_o(status_o), .bulk_attached_i(bulk_attached_i),
    .coupler_live_i(coupler_live_i), .bs_abort_i(bs_abort_i),
    .bs_parity_err_i(bs_parity_err_i), .bs_rd_req_o(bs_rd_req_o),
    .bs_rd_addr_o(bs_rd_addr_o), .bs_rd_count_o(bs_rd_count_o),
    .bs_rdata_valid_i(bs_rdata_valid_i), .bs_rdata_ready_o(bs_rdata_ready_o),
    .bs_rdata_i(bs_rdata_i), .bs_wr_valid_o(bs_wr_valid_o), .bs_wr_ready_i(bs_wr_ready_i),
    .bs_wr_data_o(bs_wr_data_o), .bs_wr_addr_o(bs_wr_addr_o));

  bst_bulk_model u_bulk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .rd_req_i(bs_rd_req_o),
    .rd_addr_i(bs_rd_addr_o), .rd_count_i(bs_rd_count_o), .rdata_valid_o(bs_rdata_valid_i),
    .rdata_ready_i(bs_rdata_ready_o), .rdata_o(bs_rdata_i), .wr_valid_i(bs_wr_valid_o),
    .wr_ready_o(bs_wr_ready_i), .wr_data_i(bs_wr_data_o), .wr_addr_i(bs_wr_addr_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) cyc++;
  always @(negedge ref_clk_i) begin
    if (bs_rd_req_o === 1'b1) begin
      req_seen = 1;
      req_cyc = cyc;
      req_cnt = int'(bs_rd_count_o);
      req_addr = bs_rd_addr_o;
    end
  end

  // reference model of the bulk write stream: one queued word per beat
  always @(negedge ref_clk_i) begin
    if (bs_wr_valid_o === 1'b1 && bs_wr_ready_i === 1'b1) begin
      w_ok = exp_q.size() > 0;
      if (w_ok) w_ok = (bs_wr_data_o === exp_q[0]) && (bs_wr_addr_o === exp_addr);
      chk(w_ok, "bulk write word");
      if (exp_q.size() > 0) void'(exp_q.pop_front());
      exp_addr = ADDR_W'(exp_addr + 1);
    end
  end

  // ***********************
  // shared tasks
  // ***********************
  task automatic chk(input logic c, input string m);
    n_checks++;
    if (c !== 1'b1) begin
      err_total++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic issue(input logic [OP_W-1:0] o, input logic [OP_W-1:0] d,
                       input logic [ADDR_W-1:0] a);
    @(negedge ref_clk_i);
    instr_valid_i = 1'b1;
    opcode_i = o;
    d_field_i = d;
    acc_i = a;
    @(negedge ref_clk_i);
    instr_valid_i = 1'b0;
    acc_cyc = cyc;
  endtask

  task automatic wait_done(input int lim);
    // done stands one cycle and may already be up where issue returns
    n = 1;
    while (instr_done_o !== 1'b1 && n < lim) begin
      @(negedge ref_clk_i);
      n++;
      if (n == 3) snap = status_o;
    end
    if (instr_done_o !== 1'b1) begin
      chk(1'b0, "no completion");
      give_verdict();
    end
  endtask

  // ***********************
  // main sequence
  // ***********************
  initial begin
    {instr_valid_i, opcode_i, d_field_i, acc_i} = '0;
    {bulk_attached_i, coupler_live_i, bs_abort_i, bs_parity_err_i} = 4'h0;
    rst_b_i = 1'b0;
    void'($urandom(51835));
    k = 2 + ($urandom % 7);
    dm_a = 18'h40 + ADDR_W'($urandom % 64);
    bs1 = ADDR_W'($urandom);
    bs2 = ADDR_W'($urandom);
    // descriptors at distributive addresses 0 and 1: bank 0 and bank 1, row 0
    u_dut.bank_mem[0][0] = {6'h00, ADDR_W'(k), dm_a, bs1};
    u_dut.bank_mem[1][0] = {6'h00, ADDR_W'(k), dm_a, bs2};
    repeat (5) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    for (int i = 0; i < 4; i++) begin
      live = $urandom;
      coupler_live_i = live;
      repeat (5) @(negedge ref_clk_i);
      issue(OP_STAT, $urandom, $urandom);
      wait_done(4);
      chk(n == 1, "status read latency");
      chk(status_o[STAT_LIVE] === live, "live bit");
    end
    for (int i = 0; i < 4; i++) begin
      op = $urandom;
      if (op == OP_XFER || op == OP_STAT) op = 6'h00;
      issue(op, 6'h00, 18'h0);
      seen = 0;
      repeat (4) @(negedge ref_clk_i) if (instr_done_o !== 1'b0 || busy_o !== 1'b0) seen = 1;
      chk(!seen, "unknown opcode acted");
    end
    @(negedge ref_clk_i);
    {bs_abort_i, bs_parity_err_i} = 2'h3;
    @(negedge ref_clk_i);
    {bs_abort_i, bs_parity_err_i} = 2'h0;
    @(negedge ref_clk_i);
    chk(status_o[STAT_ABORT:STAT_PARITY] === 2'h3, "flags not set");
    req_seen = 0;
    issue(OP_XFER, 6'h00, 18'h0);
    wait_done(4);
    chk(n == 1 && busy_o === 1'b0 && !req_seen, "pass acted");
    chk(status_o[STAT_ABORT:STAT_PARITY] === 2'h3, "pass changed flags");
    bulk_attached_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    // absolute descriptor address, no relocation applied
    req_seen = 0;
    rd0 = u_bulk.n_rd;
    issue(OP_XFER, {5'h0, DIR_TO_DM}, 18'h0);
    wait_done(20000);
    chk(snap[STAT_ABORT:STAT_PARITY] === 2'h0, "flags not cleared");
    chk(req_seen && req_cyc == acc_cyc + 40 && req_addr === bs1, "bulk read request");
    chk(u_bulk.n_rd - rd0 == req_cnt && req_cnt == k, "words moved");
    for (int i = 0; i < k; i++) begin
      wa = ADDR_W'(bs1 + i);
      exp_q.push_back({6'h2A, wa, ~wa, wa});
    end
    exp_addr = bs2;
    req_seen = 0;
    issue(OP_XFER, {5'h0, DIR_TO_BULK}, 18'h1);
    wait_done(20000);
    chk(!req_seen, "read in write direction");
    chk(exp_q.size() == 0, "bulk words missing");
    chk(u_bulk.wr_err == 0, "write address order");
    issue(OP_STAT, 6'h00, 18'h0);
    wait_done(4);
    chk(n == 1, "back to back status read");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
